//--- verilog/ebh_pkg.sv
// Package: constants, states and carrier types of the external bus hold and wait-state block
package ebh_pkg;

	// ==========================================================
	// Widths and counts
	localparam int          WAIT_W        = 3;
	localparam logic [2:0]  MIN_RDY_WAITS = 3'h2;
	localparam logic [2:0]  LAST_WAIT     = 3'h1;
	localparam int          SYNC_STAGES   = 2;

	// ==========================================================
	// Values after reset
	localparam logic        RST_ACK_N     = 1'b1;
	localparam logic        RST_STROBE_N  = 1'b1;
	localparam logic        RST_DONE_N    = 1'b1;
	localparam logic        RST_FETCH_N   = 1'b1;
	localparam logic        RST_OE_N      = 1'b0;
	localparam logic        RST_SYNC      = 1'b1;
	localparam logic [2:0]  RST_CNT       = 3'h0;

	// ==========================================================
	// Access sequencer states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_STRB   = 3'b001,
		ST_WAIT   = 3'b010,
		ST_SETTLE = 3'b011,
		ST_RDY    = 3'b100,
		ST_HOLD   = 3'b101
	} ebh_state_t;

	// ==========================================================
	// Access request from the core
	typedef struct packed {
		logic              valid;
		logic              fetch;
		logic [WAIT_W-1:0] waits;
	} ebh_req_t;

endpackage

//--- verilog/ebh_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ebh_sync (
	input  wire logic CLK_SYS, // System clock
	input  wire logic RST_N,   // Synchronous reset, active low
	input  wire logic D,       // Asynchronous pin level
	output logic      Q        // Synchronised level
);
	import ebh_pkg::*;

	logic meta;
	logic next_meta;
	logic next_q;

	// First stage feeds only the second stage
	always_comb begin
		next_meta = RST_N ? D : RST_SYNC;
		next_q    = RST_N ? meta : RST_SYNC;
	end

	always_ff @(posedge CLK_SYS) begin
		meta <= next_meta;
		Q    <= next_q;
	end
endmodule

//--- verilog/ebh_top.sv
// External bus hold grant, wait-state completion and fetch status outputs
//
// Operation
// [R1] While in hold the grant acknowledge is low and address, data and control lines float.
// [R2] Outside reset, the grant acknowledge output floats whenever the float input is low.
// [R3] The grant acknowledge output is driven high throughout reset.
// [R4] With two or more wait states the wait-state-done output is low in the last wait state.
// [R5] Looping wait-state-done back to ready adds exactly one external wait state.
// [R6] Outside reset, the wait-state-done output floats whenever the float input is low.
// [R7] The fetch output is low while a fetch address is on the bus and high otherwise.
// [R8] Outside reset, the fetch output floats whenever the float input is low.
// [R9] An external master asks with an active-low hold request and gets the bus lines floated.
// [R10] Ready is checked only after the wait states and only with two or more of them; low waits.
// [R11] In hold the memory strobe and the other strobes and selects float.
// [R12] Hold is granted only at an access boundary, with acknowledge and float in the same cycle.
`timescale 1ns/1ps
module ebh_top (
	input  wire logic            CLK_SYS,                // System clock, 250 MHz
	input  wire logic            RST_N,                  // Synchronous reset, active low
	input  wire logic            HOLD_REQ_N,             // Pin: bus request from other master
	input  wire logic            READY,                  // Pin: external device ready
	input  wire logic            OUT_FLOAT_N,            // Pin: float all outputs when low, outside reset
	input  wire ebh_pkg::ebh_req_t ACC_REQ,              // Core access request
	output logic                 ACC_READY,              // Request is taken this cycle, outside reset
	output logic                 ACC_DONE,               // Access completes this cycle
	output logic                 BUS_GRANT_ACK_N,        // Pin level: hold acknowledge
	output logic                 BUS_GRANT_ACK_OE_N,     // Pin enable, low drives
	output logic                 WAITSTATE_DONE_N,       // Pin level: last wait state
	output logic                 WAITSTATE_DONE_OE_N,    // Pin enable, low drives
	output logic                 FETCH_ADDR_VALID_N,     // Pin level: fetch address on bus
	output logic                 FETCH_ADDR_VALID_OE_N,  // Pin enable, low drives
	output logic                 MEM_ACCESS_STROBE_N,    // Pin level: memory strobe
	output logic                 MEM_ACCESS_STROBE_OE_N, // Pin enable, low drives
	output logic                 BUS_LINES_OE_N          // Address, data, selects enable
);
	import ebh_pkg::*;

	// ==========================================================
	// Pin synchronisers
	logic hold_s;
	logic ready_s;
	logic float_s;

	ebh_sync u_sync_hold (
		.CLK_SYS (CLK_SYS),
		.RST_N   (RST_N),
		.D       (HOLD_REQ_N),
		.Q       (hold_s)
	);
	ebh_sync u_sync_ready (
		.CLK_SYS (CLK_SYS),
		.RST_N   (RST_N),
		.D       (READY),
		.Q       (ready_s)
	);
	ebh_sync u_sync_float (
		.CLK_SYS (CLK_SYS),
		.RST_N   (RST_N),
		.D       (OUT_FLOAT_N),
		.Q       (float_s)
	);

	// ==========================================================
	// Access sequencer
	ebh_state_t        state;
	ebh_state_t        next_state;
	logic [WAIT_W-1:0] cnt;
	logic [WAIT_W-1:0] next_cnt;
	logic [WAIT_W-1:0] waits;
	logic [WAIT_W-1:0] next_waits;
	logic              fetch;
	logic              next_fetch;
	logic              done;

	assign ACC_READY = (state == ST_IDLE) && hold_s;
	assign ACC_DONE  = done;

	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		next_waits = waits;
		next_fetch = fetch;
		done       = 1'b0;
		case (state)
			ST_IDLE: begin
				if (!hold_s) begin
					next_state = ST_HOLD; // R12
				end else if (ACC_REQ.valid) begin
					next_state = ST_STRB;
					next_waits = ACC_REQ.waits;
					next_fetch = ACC_REQ.fetch;
				end
			end
			ST_STRB: begin
				if (waits == RST_CNT) begin
					done       = 1'b1;
					next_state = ST_IDLE;
				end else begin
					next_cnt   = waits;
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				next_cnt = cnt - LAST_WAIT;
				if (cnt == LAST_WAIT) begin
					if (waits >= MIN_RDY_WAITS) begin
						next_state = ST_SETTLE; // R10
					end else begin
						done       = 1'b1;
						next_state = ST_IDLE;
					end
				end
			end
			// Covers the synchroniser delay so a looped-back low is seen once
			ST_SETTLE: begin
				next_state = ST_RDY; // R5
			end
			ST_RDY: begin
				if (ready_s) begin
					done       = 1'b1;
					next_state = ST_IDLE;
				end // R10
			end
			ST_HOLD: begin
				if (hold_s) begin
					next_state = ST_IDLE; // R9
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		if (!RST_N) begin
			next_state = ST_IDLE;
			next_cnt   = RST_CNT;
			next_waits = RST_CNT;
			next_fetch = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		state <= next_state;
		cnt   <= next_cnt;
		waits <= next_waits;
		fetch <= next_fetch;
	end

	// ==========================================================
	// Registered pin outputs, computed from the next state so they line up with it
	logic next_busy;
	logic next_holding;
	logic next_ack_n;
	logic next_done_n;
	logic next_fetch_n;
	logic next_strobe_n;
	logic next_oe_n;
	logic next_bus_oe_n;

	always_comb begin
		next_busy     = (next_state == ST_STRB) || (next_state == ST_WAIT) ||
			(next_state == ST_SETTLE) || (next_state == ST_RDY);
		next_holding  = (next_state == ST_HOLD);
		next_ack_n    = !next_holding; // R1
		next_done_n   = !((next_state == ST_WAIT) && (next_cnt == LAST_WAIT) &&
			(next_waits >= MIN_RDY_WAITS)); // R4
		next_fetch_n  = !(next_busy && next_fetch); // R7
		next_strobe_n = !next_busy;
		next_oe_n     = !float_s; // R2 R6 R8
		next_bus_oe_n = !float_s || next_holding; // R11
		if (!RST_N) begin
			next_ack_n    = RST_ACK_N; // R3
			next_done_n   = RST_DONE_N;
			next_fetch_n  = RST_FETCH_N;
			next_strobe_n = RST_STROBE_N;
			next_oe_n     = RST_OE_N;
			next_bus_oe_n = RST_OE_N;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		BUS_GRANT_ACK_N        <= next_ack_n;
		BUS_GRANT_ACK_OE_N     <= next_oe_n;
		WAITSTATE_DONE_N       <= next_done_n;
		WAITSTATE_DONE_OE_N    <= next_oe_n;
		FETCH_ADDR_VALID_N     <= next_fetch_n;
		FETCH_ADDR_VALID_OE_N  <= next_oe_n;
		MEM_ACCESS_STROBE_N    <= next_strobe_n;
		MEM_ACCESS_STROBE_OE_N <= next_bus_oe_n;
		BUS_LINES_OE_N         <= next_bus_oe_n;
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	logic busy_q;
	assign busy_q = (state == ST_STRB) || (state == ST_WAIT) ||
		(state == ST_SETTLE) || (state == ST_RDY);

	a_hold_lines_float: assert property ( // R1
		!BUS_GRANT_ACK_N |-> BUS_LINES_OE_N && MEM_ACCESS_STROBE_OE_N && state == ST_HOLD)
		else $error("Hold acknowledged while bus lines still driven");
	a_ack_float_off: assert property ( // R2
		!float_s |=> BUS_GRANT_ACK_OE_N)
		else $error("Grant acknowledge driven while float requested");
	// Own disable, the default one would switch this check off for the whole reset
	a_reset_ack_high: assert property (@(posedge CLK_SYS) disable iff (1'b0) // R3
		!RST_N |=> BUS_GRANT_ACK_N && !BUS_GRANT_ACK_OE_N)
		else $error("Grant acknowledge not high after reset cycle");
	a_done_last_wait: assert property ( // R4
		!WAITSTATE_DONE_N |-> state == ST_WAIT && cnt == LAST_WAIT && waits >= MIN_RDY_WAITS)
		else $error("Wait-state-done low outside last wait state");
	a_loop_one_extra: assert property ( // R5
		!WAITSTATE_DONE_N |=> state == ST_SETTLE ##1 state == ST_RDY)
		else $error("Ready check not placed after last wait state");
	a_done_float_off: assert property ( // R6
		!float_s |=> WAITSTATE_DONE_OE_N)
		else $error("Wait-state-done driven while float requested");
	a_fetch_level: assert property ( // R7
		FETCH_ADDR_VALID_N == !(busy_q && fetch))
		else $error("Fetch output does not follow fetch address phase");
	a_fetch_float_off: assert property ( // R8
		!float_s |=> FETCH_ADDR_VALID_OE_N)
		else $error("Fetch output driven while float requested");
	a_grant_needs_req: assert property ( // R9
		$fell(BUS_GRANT_ACK_N) |-> !$past(hold_s))
		else $error("Hold granted without a request");
	a_ready_wait: assert property ( // R10
		state == ST_RDY && !ready_s |-> !ACC_DONE ##1 state == ST_RDY)
		else $error("Access ended while ready was low");
	a_hold_strobe_off: assert property ( // R11
		state == ST_HOLD |-> MEM_ACCESS_STROBE_OE_N && MEM_ACCESS_STROBE_N)
		else $error("Memory strobe driven in hold");
	a_grant_boundary: assert property ( // R12
		busy_q |=> state != ST_HOLD)
		else $error("Hold granted in the middle of an access");

	c_hold_grant: cover property ($fell(BUS_GRANT_ACK_N));
	c_ready_stall: cover property (state == ST_RDY && !ready_s ##1 ACC_DONE);
	c_fetch_waits: cover property (ACC_DONE && fetch && waits >= MIN_RDY_WAITS);
	c_float: cover property (!float_s ##1 BUS_GRANT_ACK_OE_N);
endmodule

//--- verif/ebh_far_end.sv
// Far-side model: another bus master and a slow external memory
`timescale 1ns/1ps
module ebh_far_end (
	input  wire logic clk_sys,    // System clock
	input  wire logic want_bus,   // Scenario asks for the bus
	input  wire logic ready_low,  // Scenario stalls the memory
	input  wire logic loop,       // Wait-state-done looped to ready
	input  wire logic done_n,     // Wait-state-done pin from the block
	output logic      hold_req_n, // Bus request pin
	output logic      ready       // Ready pin
);
	logic mem_ready = 1'b1;
	logic next_mem_ready;
	assign hold_req_n = ~want_bus;
	always_comb begin
		next_mem_ready = ~ready_low;
	end
	// Memory answers one cycle late, as a slow part would
	always_ff @(posedge clk_sys) begin
		mem_ready <= next_mem_ready;
	end
	assign ready = loop ? done_n : mem_ready;
endmodule

//--- verif/ebh_top_test.sv
// Self-checking testbench of the external bus hold and wait-state block
`timescale 1ns/1ps
module ebh_top_test;
	import ebh_pkg::*;
	logic     clk_sys = 1'b0;
	logic     rst_n = 1'b0, out_float_n = 1'b1, want_bus = 1'b0, ready_low = 1'b0, loop = 1'b0;
	ebh_req_t acc_req = '0;
	logic     hold_req_n, ready, acc_ready, acc_done, ack_n, ack_oe_n, done_n, done_oe_n;
	logic     fetch_n, fetch_oe_n, strobe_n, strobe_oe_n, lines_oe_n;
	int       n_mismatch = 0, checks_done = 0, cycles = 0;
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	ebh_top dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .HOLD_REQ_N(hold_req_n), .READY(ready),
		.OUT_FLOAT_N(out_float_n), .ACC_REQ(acc_req), .ACC_READY(acc_ready), .ACC_DONE(acc_done),
		.BUS_GRANT_ACK_N(ack_n), .BUS_GRANT_ACK_OE_N(ack_oe_n), .WAITSTATE_DONE_N(done_n),
		.WAITSTATE_DONE_OE_N(done_oe_n), .FETCH_ADDR_VALID_N(fetch_n),
		.FETCH_ADDR_VALID_OE_N(fetch_oe_n), .MEM_ACCESS_STROBE_N(strobe_n),
		.MEM_ACCESS_STROBE_OE_N(strobe_oe_n), .BUS_LINES_OE_N(lines_oe_n));
	ebh_far_end far (.clk_sys(clk_sys), .want_bus(want_bus), .ready_low(ready_low), .loop(loop),
		.done_n(done_n), .hold_req_n(hold_req_n), .ready(ready));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic got, input logic exp, input string what);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask
	task automatic chk_n(input int got, input int lo, input int hi, input string what);
		checks_done++;
		if (got < lo || got > hi) begin
			n_mismatch++;
			$display("mismatch at %0t: %s gave %0d", $time, what, got);
		end
	endtask
	// ==========================================================
	// One access; rel releases a stalled ready after that many cycles
	task automatic acc(input logic [2:0] w, input logic f, input int lo, input int hi, input int rel);
		int   n;
		int   lows;
		logic fin;
		n = 0;
		lows = 0;
		fin = 1'b0;
		@(posedge clk_sys);
		acc_req <= '{valid: 1'b1, fetch: f, waits: w};
		do @(negedge clk_sys); while (acc_ready !== 1'b1);
		@(posedge clk_sys);
		acc_req <= '0;
		do begin
			@(negedge clk_sys);
			n++;
			fin = acc_done;
			chk(fetch_n, ~f, "fetch level");
			chk(strobe_n, 1'b0, "strobe level");
			chk(ack_n, 1'b1, "grant mid-access");
			if (done_n === 1'b0) lows++;
			if (n == rel) begin
				@(posedge clk_sys);
				ready_low <= 1'b0;
			end
		end while (fin !== 1'b1 && n < 40);
		chk_n(n, lo, hi, "access length");
		chk_n(lows, int'(w >= 3'h2), int'(w >= 3'h2), "last wait marker");
		@(negedge clk_sys);
		chk(fetch_n, 1'b1, "fetch idle");
	endtask
	// ==========================================================
	// Scenarios
	task automatic plain_waits;
		acc(3'h0, 1'b1, 1, 1, 0);
		acc(3'h1, 1'b0, 2, 2, 0);
		acc(3'h2, 1'b1, 5, 5, 0);
		acc(3'h7, 1'b0, 10, 10, 0);
	endtask
	task automatic stalled_ready;
		@(posedge clk_sys);
		ready_low <= 1'b1;
		repeat (4) @(posedge clk_sys);
		acc(3'h1, 1'b0, 2, 2, 0);
		acc(3'h2, 1'b1, 13, 18, 12);
		@(posedge clk_sys);
		loop <= 1'b1;
		acc(3'h3, 1'b0, 7, 7, 0);
		@(posedge clk_sys);
		loop <= 1'b0;
	endtask
	task automatic hold_idle;
		@(posedge clk_sys);
		want_bus <= 1'b1;
		repeat (3) @(negedge clk_sys);
		chk(ack_n, 1'b1, "grant too early");
		@(negedge clk_sys);
		chk(ack_n, 1'b0, "grant");
		chk(lines_oe_n, 1'b1, "lines float");
		chk(strobe_oe_n, 1'b1, "strobe float");
		chk(acc_ready, 1'b0, "no access in hold");
		@(posedge clk_sys);
		want_bus <= 1'b0;
		repeat (4) @(negedge clk_sys);
		chk(ack_n, 1'b1, "grant released");
		chk(lines_oe_n, 1'b0, "lines driven");
	endtask
	task automatic hold_mid_access;
		fork
			acc(3'h3, 1'b1, 6, 6, 0);
			begin
				repeat (2) @(posedge clk_sys);
				want_bus <= 1'b1;
			end
		join
		repeat (3) @(negedge clk_sys);
		chk(ack_n, 1'b0, "grant after access");
		chk(lines_oe_n, 1'b1, "float with grant");
		@(posedge clk_sys);
		want_bus <= 1'b0;
		repeat (4) @(negedge clk_sys);
	endtask
	task automatic reset_in_hold;
		@(posedge clk_sys);
		want_bus <= 1'b1;
		repeat (4) @(negedge clk_sys);
		chk(ack_n, 1'b0, "grant before reset");
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(negedge clk_sys);
		chk(ack_n, 1'b1, "grant high in mid-run reset");
		chk(ack_oe_n, 1'b0, "grant driven in mid-run reset");
		@(posedge clk_sys);
		want_bus <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(negedge clk_sys);
		chk(ack_n, 1'b1, "grant after mid-run reset");
		chk(lines_oe_n, 1'b0, "lines driven after reset");
	endtask
	task automatic float_all;
		@(posedge clk_sys);
		out_float_n <= 1'b0;
		repeat (4) @(negedge clk_sys);
		chk(ack_oe_n, 1'b1, "grant floats");
		chk(done_oe_n, 1'b1, "marker floats");
		chk(fetch_oe_n, 1'b1, "fetch floats");
		chk(strobe_oe_n, 1'b1, "strobe floats");
		chk(lines_oe_n, 1'b1, "lines float");
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			end_sim();
		end
	end
	initial begin
		repeat (5) @(negedge clk_sys);
		chk(ack_n, 1'b1, "grant in reset");
		chk(ack_oe_n, 1'b0, "grant driven in reset");
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		plain_waits();
		stalled_ready();
		hold_idle();
		hold_mid_access();
		reset_in_hold();
		float_all();
		end_sim();
	end
endmodule
